// >>> prv_pkg.sv
// Shared constants and types for the program memory sequencer
`default_nettype none

package prv_pkg;

    // Program memory geometry
    localparam int PC_W = 12;
    localparam int ROM_WORDS = 3072;
    localparam int ROM_DATA_W = 16;
    localparam int STACK_DEPTH = 8;

    // Fixed vector addresses
    localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h008;

    // Interrupt sources sharing the one vector
    localparam int IRQ_SRC_N = 4;
    localparam int IRQ_TIMER_ZERO = 0;
    localparam int IRQ_USB = 1;
    localparam int IRQ_WAKEUP = 2;
    localparam int IRQ_EXTERNAL = 3;

    // Status flag register layout
    localparam int FLAG_TIMEOUT_BIT = 7;
    localparam int FLAG_POWERDOWN_BIT = 6;
    localparam int FLAG_ARITH_W = 3;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;

    // Reset cause codes, timeout flag in the upper bit
    localparam logic [1:0] CAUSE_POWER_ON = 2'h2;
    localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
    localparam logic [1:0] CAUSE_EXTERNAL = 2'h3;

    typedef enum logic [2:0] {
        OP_NEXT,
        OP_JUMP,
        OP_CALL,
        OP_RET,
        OP_INTERRUPT_RETURN,
        OP_SAVE,
        OP_RESTORE,
        OP_TREAD
    } prv_op_t;

    typedef enum logic {
        ST_RUN,
        ST_TBL
    } prv_state_t;

    typedef struct packed {
        logic valid;
        prv_op_t op;
        logic [PC_W-1:0] target;
    } prv_cmd_t;

endpackage

`default_nettype wire

// >>> prv_stack.sv
// Return address stack held in flip-flops
`timescale 1ns/10ps
`default_nettype none

module prv_stack #(
    parameter int DEPTH = prv_pkg::STACK_DEPTH,
    parameter int W = prv_pkg::PC_W
) (
    input wire logic clk_sys_i,
    input wire logic clr_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [W-1:0] push_data_i,
    output logic [W-1:0] top_o,
    output logic [$clog2(DEPTH+1)-1:0] depth_o
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("stack depth must be a power of two");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] ptr_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PTR_W-1:0] top_idx;

    // Oldest entry is overwritten once all levels are in use
    assign top_idx = ptr_q - PTR_W'(1);
    assign top_o = mem_q[top_idx];
    assign depth_o = cnt_q;

    always_ff @(posedge clk_sys_i) begin
        if (push_i) begin
            mem_q[ptr_q] <= push_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clr_i) begin
            ptr_q <= '0;
            cnt_q <= '0;
        end else if (push_i) begin
            ptr_q <= ptr_q + PTR_W'(1);
            cnt_q <= (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CNT_W'(1);
        end else if (pop_i) begin
            ptr_q <= top_idx;
            cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// >>> prv_core.sv
// Program counter, vectors, reset cause, save buffer and table read
// Operation
// [R1] Program memory is 3K words of 16 bits, reached by PC and table pointers.
// [R2] Each instruction is one word; table read takes two cycles, others one.
// [R3] Word 0000H is the reset vector; every system reset fetches there.
// [R4] Reset cause flags: power-on 1/0, watchdog 0/0, external 1/1.
// [R5] Any reset kind restores register defaults and fetches from 0000h.
// [R6] Serviced interrupt pushes the PC and continues at 0008h.
// [R7] Return stack keeps up to 8 program counter entries.
// [R8] Timer zero, USB, wakeup and external input share one vector.
// [R9] Save copies work register and flags; restore reloads; cause flags untouched.
// [R10] Save buffer is one level deep; a second save overwrites.
// [R11] Table address is middle pointer bits 15:8, low pointer bits 7:0.
// [R12] Table read puts low byte in work register, high byte in lookup register.
// [R13] No carry from low table pointer into middle pointer on wrap.
// [R14] Optional reset pin is active low, rests high, Schmitt input.
// [R15] Interrupt return pops the latest pushed PC and resumes there.
// [R16] PC spans the whole 3K space; table address folds into that range.
`timescale 1ns/10ps
`default_nettype none

module prv_core #(
    parameter int ROM_WORDS = prv_pkg::ROM_WORDS,
    parameter int STACK_DEPTH = prv_pkg::STACK_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic wdt_rst_i,
    input wire logic ext_rst_en_i,
    input wire logic ext_rst_pin_n_i,
    input wire prv_pkg::prv_cmd_t cmd_i,
    input wire logic irq_en_i,
    input wire logic [2:0] int_src_i,
    input wire logic external_irq_input_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic flag_we_i,
    input wire logic [2:0] flag_wdata_i,
    input wire logic [7:0] tbl_mid_i,
    input wire logic [7:0] tbl_low_i,
    input wire logic [15:0] rom_data_i,
    output logic [prv_pkg::PC_W-1:0] pc_o,
    output logic [prv_pkg::PC_W-1:0] rom_addr_o,
    output logic [7:0] primary_work_reg_o,
    output logic [7:0] status_flag_reg_o,
    output logic [7:0] lookup_high_o,
    output logic busy_o,
    output logic irq_taken_o
);

    localparam int PC_W = prv_pkg::PC_W;
    localparam int AW = prv_pkg::FLAG_ARITH_W;
    localparam int CNT_W = $clog2(STACK_DEPTH+1);
    localparam logic [PC_W-1:0] PC_LAST = PC_W'(ROM_WORDS - 1);
    localparam logic [15:0] ROM_SPAN = 16'(ROM_WORDS);

    // Refuse sizes that the vectors or the program counter cannot serve
    if (ROM_WORDS <= 9 || ROM_WORDS > (1 << PC_W)) begin : g_bad_rom
        $error("ROM_WORDS must cover the vectors and fit the program counter");
    end

    // Reset pin crosses in through two flops, resting high
    logic [1:0] ext_sync_q;
    logic [1:0] irq_sync_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ext_sync_q <= 2'h3;
            irq_sync_q <= 2'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_rst_pin_n_i};
            irq_sync_q <= {irq_sync_q[0], external_irq_input_i};
        end
    end

    wire ext_rst_w = ext_rst_en_i && !ext_sync_q[1]; // [R14]
    wire sys_rst_w = !rstn_i || wdt_rst_i || ext_rst_w;

    // State
    prv_pkg::prv_state_t state_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] rom_addr_q;
    logic [7:0] acc_q;
    logic [AW-1:0] arith_q;
    logic [1:0] cause_q;
    logic [7:0] high_q;
    logic [7:0] save_acc_q;
    logic [AW-1:0] save_arith_q;
    logic busy_q;
    logic irq_taken_q;

    // Stack
    logic [PC_W-1:0] stack_top;
    logic [CNT_W-1:0] stack_depth;

    // Command decode
    wire run_w = (state_q == prv_pkg::ST_RUN);
    wire go_w = run_w && cmd_i.valid && !sys_rst_w;
    wire [prv_pkg::IRQ_SRC_N-1:0] irq_src_w = {irq_sync_q[1], int_src_i};
    // Interrupts are only taken on a plain sequential step
    wire irq_go_w = go_w && (cmd_i.op == prv_pkg::OP_NEXT) && irq_en_i
        && (|irq_src_w); // [R8]
    wire jump_w = go_w && (cmd_i.op == prv_pkg::OP_JUMP);
    wire call_w = go_w && (cmd_i.op == prv_pkg::OP_CALL);
    wire ret_w = go_w && (cmd_i.op == prv_pkg::OP_RET || cmd_i.op == prv_pkg::OP_INTERRUPT_RETURN);
    wire save_w = go_w && (cmd_i.op == prv_pkg::OP_SAVE);
    wire restore_w = go_w && (cmd_i.op == prv_pkg::OP_RESTORE);
    wire tread_w = go_w && (cmd_i.op == prv_pkg::OP_TREAD);
    wire tcap_w = !run_w && !sys_rst_w;

    wire push_w = call_w || irq_go_w; // [R6]
    wire pop_w = ret_w; // [R15]

    // Sequential program counter wraps at the top of memory
    wire [PC_W-1:0] pc_inc_w = (pc_q == PC_LAST) ? '0 : pc_q + PC_W'(1); // [R16]
    wire [PC_W-1:0] call_tgt_w = (cmd_i.target > PC_LAST) ? PC_LAST : cmd_i.target;

    // Pointers are joined as they stand; the low pointer never carries
    wire [15:0] tbl_raw_w = {tbl_mid_i, tbl_low_i}; // [R11] [R13]
    wire [15:0] tbl_fold_w = (tbl_raw_w % ROM_SPAN);
    wire [PC_W-1:0] tbl_addr_w = tbl_fold_w[PC_W-1:0]; // [R16] [R1]

    wire [PC_W-1:0] pc_d = irq_go_w ? prv_pkg::IRQ_VECTOR // [R6]
        : (jump_w || call_w) ? call_tgt_w
        : ret_w ? stack_top // [R15]
        : go_w ? pc_inc_w // [R2]
        : pc_q;

    wire [PC_W-1:0] rom_addr_d = tread_w ? tbl_addr_w : pc_d; // [R1]

    wire [7:0] acc_d = tcap_w ? rom_data_i[7:0] // [R12]
        : restore_w ? save_acc_q // [R9]
        : acc_we_i ? acc_wdata_i
        : acc_q;

    wire [AW-1:0] arith_d = restore_w ? save_arith_q // [R9]
        : flag_we_i ? flag_wdata_i
        : arith_q;

    // Reset cause follows the highest priority source present
    wire [1:0] cause_d = !rstn_i ? prv_pkg::CAUSE_POWER_ON // [R4]
        : wdt_rst_i ? prv_pkg::CAUSE_WATCHDOG
        : prv_pkg::CAUSE_EXTERNAL;

    prv_stack #(
        .DEPTH(STACK_DEPTH),
        .W(PC_W)
    ) u_stack (
        .clk_sys_i(clk_sys_i),
        .clr_i(sys_rst_w),
        .push_i(push_w), // [R7]
        .pop_i(pop_w),
        .push_data_i(pc_inc_w),
        .top_o(stack_top),
        .depth_o(stack_depth)
    );

    // Program counter and fetch address
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_w) begin
            pc_q <= prv_pkg::RESET_VECTOR; // [R3] [R5]
            rom_addr_q <= prv_pkg::RESET_VECTOR; // [R3]
        end else begin
            pc_q <= pc_d;
            rom_addr_q <= rom_addr_d;
        end
    end

    // Table read holds the sequencer for a second cycle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_w) begin
            state_q <= prv_pkg::ST_RUN;
            busy_q <= 1'b0;
        end else begin
            state_q <= tread_w ? prv_pkg::ST_TBL : prv_pkg::ST_RUN; // [R2]
            busy_q <= tread_w;
        end
    end

    // Work register, flags and lookup result
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_w) begin
            acc_q <= prv_pkg::ACC_RESET; // [R5]
            arith_q <= prv_pkg::FLAG_RESET[AW-1:0];
            high_q <= 8'h00;
            cause_q <= cause_d; // [R4]
        end else begin
            acc_q <= acc_d;
            arith_q <= arith_d;
            if (tcap_w) begin
                high_q <= rom_data_i[15:8]; // [R12]
            end
        end
    end

    // One-level save buffer; cause flags are never copied
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_w) begin
            save_acc_q <= 8'h00;
            save_arith_q <= '0;
        end else if (save_w) begin
            save_acc_q <= acc_q; // [R9] [R10]
            save_arith_q <= arith_q;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_w) begin
            irq_taken_q <= 1'b0;
        end else begin
            irq_taken_q <= irq_go_w;
        end
    end

    assign pc_o = pc_q;
    assign rom_addr_o = rom_addr_q;
    assign primary_work_reg_o = acc_q;
    assign status_flag_reg_o = {cause_q, 3'h0, arith_q};
    assign lookup_high_o = high_q;
    assign busy_o = busy_q;
    assign irq_taken_o = irq_taken_q;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking

    sequence tbl_start_s;
        tread_w;
    endsequence

    sequence tbl_finish_s;
        busy_o ##1 !busy_o;
    endsequence

    reset_vector_fetch_a: assert property (disable iff (!rstn_i) // [R3] [R5]
        wdt_rst_i |=> pc_o == prv_pkg::RESET_VECTOR && rom_addr_o == prv_pkg::RESET_VECTOR
        && busy_o == 1'b0 && primary_work_reg_o == prv_pkg::ACC_RESET)
        else $error("reset did not restart at the reset vector");

    watchdog_cause_a: assert property (disable iff (!rstn_i) // [R4]
        wdt_rst_i |=> status_flag_reg_o[7:6] == prv_pkg::CAUSE_WATCHDOG)
        else $error("watchdog reset cause flags wrong");

    external_cause_a: assert property (disable iff (!rstn_i) // [R4] [R14]
        (ext_rst_w && !wdt_rst_i) |=> status_flag_reg_o[7:6] == prv_pkg::CAUSE_EXTERNAL
        && pc_o == prv_pkg::RESET_VECTOR)
        else $error("external reset cause flags wrong");

    irq_vector_a: assert property (disable iff (sys_rst_w) // [R6] [R8]
        irq_go_w |=> pc_o == prv_pkg::IRQ_VECTOR && irq_taken_o
        && stack_top == $past(pc_inc_w))
        else $error("interrupt did not vector to 0008h");

    tbl_address_a: assert property (disable iff (sys_rst_w) // [R11] [R16]
        tbl_start_s |=> rom_addr_o == $past(tbl_addr_w) && rom_addr_o < PC_LAST + PC_W'(1))
        else $error("table read address wrong");

    tbl_two_cycle_a: assert property (disable iff (sys_rst_w) // [R2]
        tbl_start_s |=> tbl_finish_s)
        else $error("table read not exactly two cycles");

    tbl_result_a: assert property (disable iff (sys_rst_w) // [R12]
        tcap_w |=> primary_work_reg_o == $past(rom_data_i[7:0])
        && lookup_high_o == $past(rom_data_i[15:8]) && rom_addr_o == pc_o)
        else $error("table read data placed wrong");

    restore_value_a: assert property (disable iff (sys_rst_w) // [R9] [R10]
        restore_w && !tcap_w |=> primary_work_reg_o == $past(save_acc_q)
        && status_flag_reg_o[7:6] == $past(status_flag_reg_o[7:6]))
        else $error("restore did not reload the save buffer");

    return_pop_a: assert property (disable iff (sys_rst_w) // [R15]
        ret_w |=> pc_o == $past(stack_top))
        else $error("return did not resume at the stacked address");

    stack_bound_a: assert property (disable iff (sys_rst_w) // [R7]
        push_w && stack_depth == CNT_W'(STACK_DEPTH) |=> stack_depth == CNT_W'(STACK_DEPTH))
        else $error("stack depth exceeded its bound");

    // Power-on check has no disable: it must hold while rstn_i is low
    power_cause_a: assert property (!rstn_i |=> // [R4] [R5]
        status_flag_reg_o[7:6] == prv_pkg::CAUSE_POWER_ON && pc_o == prv_pkg::RESET_VECTOR)
        else $error("power-on reset cause flags wrong");

    cause_hold_a: assert property (disable iff (!rstn_i) // [R4] [R9]
        !sys_rst_w |=> $stable(status_flag_reg_o[7:6]))
        else $error("reset cause flags changed outside a reset");

    save_capture_a: assert property (disable iff (sys_rst_w) // [R9] [R10]
        save_w |=> save_acc_q == $past(acc_q) && save_arith_q == $past(arith_q))
        else $error("save buffer did not capture the work register");

    irq_pc_match_a: assert property (disable iff (sys_rst_w) // [R6]
        irq_taken_o |-> pc_o == prv_pkg::IRQ_VECTOR && stack_depth != '0)
        else $error("interrupt pulse without the vector address");

    pc_wrap_a: assert property (disable iff (sys_rst_w) // [R16]
        (go_w && cmd_i.op == prv_pkg::OP_NEXT && !irq_go_w && pc_o == PC_LAST)
        |=> pc_o == prv_pkg::RESET_VECTOR)
        else $error("program counter did not wrap at the top of memory");

endmodule

`default_nettype wire

// >>> prv_rom_model.sv
// Behavioural program ROM answering the registered fetch address
`timescale 1ns/10ps
`default_nettype none

module prv_rom_model (
    input wire logic [prv_pkg::PC_W-1:0] addr_i,
    output logic [15:0] data_o
);
    // 3K words of 16 bits, contents a fixed pattern of the address
    assign data_o = {addr_i[7:0] ^ 8'hA5, addr_i[11:4] ^ 8'h3C};
endmodule

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the program memory sequencer
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clk_sys_i, rstn_i, wdt_rst_i, ext_rst_en_i, ext_rst_pin_n_i, irq_en_i;
    logic external_irq_input_i, acc_we_i, flag_we_i, busy_o, irq_taken_o;
    logic [2:0] int_src_i, flag_wdata_i;
    logic [7:0] acc_wdata_i, tbl_mid_i, tbl_low_i, work_o, flags_o, lookup_high_o;
    logic [15:0] rom_data_i;
    logic [11:0] pc_o, rom_addr_o, epc;
    logic [11:0] stk[$];
    prv_pkg::prv_cmd_t cmd;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 91657;
    int r;

    prv_core i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wdt_rst_i(wdt_rst_i),
        .ext_rst_en_i(ext_rst_en_i), .ext_rst_pin_n_i(ext_rst_pin_n_i), .cmd_i(cmd),
        .irq_en_i(irq_en_i), .int_src_i(int_src_i),
        .external_irq_input_i(external_irq_input_i), .acc_we_i(acc_we_i),
        .acc_wdata_i(acc_wdata_i), .flag_we_i(flag_we_i), .flag_wdata_i(flag_wdata_i),
        .tbl_mid_i(tbl_mid_i), .tbl_low_i(tbl_low_i), .rom_data_i(rom_data_i),
        .pc_o(pc_o), .rom_addr_o(rom_addr_o), .primary_work_reg_o(work_o),
        .status_flag_reg_o(flags_o), .lookup_high_o(lookup_high_o), .busy_o(busy_o),
        .irq_taken_o(irq_taken_o));
    prv_rom_model i_rom (.addr_i(rom_addr_o), .data_o(rom_data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] romw(input logic [11:0] a);
        return {a[7:0] ^ 8'hA5, a[11:4] ^ 8'h3C};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic run(input prv_pkg::prv_op_t o, input logic [11:0] t, input logic irq);
        logic [11:0] n;
        n = (epc == 12'hBFF) ? 12'h000 : epc + 12'h001;
        @(posedge clk_sys_i);
        cmd <= '{valid: 1'b1, op: o, target: t};
        @(posedge clk_sys_i);
        cmd <= '0;
        case (o)
            prv_pkg::OP_CALL: begin
                if (stk.size() == 8) void'(stk.pop_front());
                stk.push_back(n);
                epc = (t > 12'hBFF) ? 12'hBFF : t;
            end
            prv_pkg::OP_JUMP: epc = (t > 12'hBFF) ? 12'hBFF : t;
            prv_pkg::OP_RET, prv_pkg::OP_INTERRUPT_RETURN: epc = stk.pop_back();
            default: epc = n;
        endcase
        if (irq) begin
            stk.push_back(n);
            epc = 12'h008;
        end
        @(negedge clk_sys_i);
        chk("pc", 16'(epc), 16'(pc_o));
        chk("irq_taken", 16'(irq), 16'(irq_taken_o));
    endtask

    task automatic rst(input int k, input logic [7:0] f);
        @(posedge clk_sys_i);
        if (k == 0) rstn_i <= 1'b0;
        else if (k == 1) wdt_rst_i <= 1'b1;
        else ext_rst_pin_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        wdt_rst_i <= 1'b0;
        ext_rst_pin_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("pc", 16'h0000, 16'(pc_o));
        chk("rom_addr", 16'h0000, 16'(rom_addr_o));
        chk("flags", 16'(f), 16'(flags_o));
        chk("work_reg", 16'h0000, 16'(work_o));
        epc = 12'h000;
        stk.delete();
        $display("test reset kind %0d done", k);
    endtask

    task automatic sr(input logic [1:0] c);
        logic [7:0] a[3];
        logic [2:0] f[3];
        for (int i = 0; i < 3; i++) begin
            a[i] = 8'($random(seed));
            f[i] = 3'($random(seed));
            @(posedge clk_sys_i);
            acc_we_i <= 1'b1;
            acc_wdata_i <= a[i];
            flag_we_i <= 1'b1;
            flag_wdata_i <= f[i];
            @(posedge clk_sys_i);
            acc_we_i <= 1'b0;
            flag_we_i <= 1'b0;
            if (i < 2) run(prv_pkg::OP_SAVE, 12'h000, 1'b0);
        end
        run(prv_pkg::OP_RESTORE, 12'h000, 1'b0);
        chk("work_reg", 16'(a[1]), 16'(work_o));
        chk("flags", 16'({c, 3'h0, f[1]}), 16'(flags_o));
        $display("test save_restore done");
    endtask

    task automatic tread(input logic [7:0] m, input logic [7:0] l);
        logic [11:0] ta;
        logic [15:0] w;
        ta = 12'({m, l} % 16'd3072);
        w = romw(ta);
        @(posedge clk_sys_i);
        tbl_mid_i <= m;
        tbl_low_i <= l;
        run(prv_pkg::OP_TREAD, 12'h000, 1'b0);
        chk("tbl_addr", 16'(ta), 16'(rom_addr_o));
        chk("busy", 16'h0001, 16'(busy_o));
        @(negedge clk_sys_i);
        chk("work_reg", 16'(w[7:0]), 16'(work_o));
        chk("lookup_high", 16'(w[15:8]), 16'(lookup_high_o));
        chk("busy", 16'h0000, 16'(busy_o));
    endtask

    initial begin
        rstn_i = 1'b0;
        {wdt_rst_i, ext_rst_en_i, irq_en_i, external_irq_input_i} = 4'h0;
        {acc_we_i, flag_we_i, int_src_i, flag_wdata_i} = 8'h00;
        {acc_wdata_i, tbl_mid_i, tbl_low_i} = 24'h000000;
        ext_rst_pin_n_i = 1'b1;
        cmd = '0;
        repeat (7) @(posedge clk_sys_i);
        rst(0, 8'h80);
        run(prv_pkg::OP_JUMP, 12'hBFF, 1'b0);
        run(prv_pkg::OP_NEXT, 12'h000, 1'b0);
        run(prv_pkg::OP_JUMP, 12'hFFF, 1'b0);
        for (int i = 0; i < 9; i++) run(prv_pkg::OP_CALL, 12'($random(seed)), 1'b0);
        for (int i = 0; i < 8; i++) run(prv_pkg::OP_RET, 12'h000, 1'b0);
        $display("test stack done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys_i);
            irq_en_i <= 1'b1;
            int_src_i <= (s < 3) ? 3'(1 << s) : 3'h0;
            external_irq_input_i <= (s == 3);
            repeat (3) @(posedge clk_sys_i);
            run(prv_pkg::OP_NEXT, 12'h000, 1'b1);
            @(posedge clk_sys_i);
            int_src_i <= 3'h0;
            external_irq_input_i <= 1'b0;
            run(prv_pkg::OP_INTERRUPT_RETURN, 12'h000, 1'b0);
        end
        @(posedge clk_sys_i);
        irq_en_i <= 1'b0;
        int_src_i <= 3'h7;
        run(prv_pkg::OP_NEXT, 12'h000, 1'b0);
        @(posedge clk_sys_i);
        int_src_i <= 3'h0;
        $display("test interrupt done");
        tread(8'h05, 8'hFF);
        tread(8'hFF, 8'hFF);
        tread(8'h00, 8'h00);
        sr(2'h2);
        repeat (30) begin
            r = $random(seed);
            if (r[1:0] == 2'd0) run(prv_pkg::OP_JUMP, r[15:4], 1'b0);
            else if (r[1:0] == 2'd1) run(prv_pkg::OP_NEXT, 12'h000, 1'b0);
            else tread(r[23:16], r[31:24]);
        end
        $display("test random done");
        rst(1, 8'h00);
        sr(2'h0);
        @(posedge clk_sys_i);
        ext_rst_en_i <= 1'b1;
        rst(2, 8'hC0);
        sr(2'h3);
        stop_test();
    end
endmodule

`default_nettype wire
